// *** pkg/ccp_defs.svh ***
`ifndef CCP_DEFS_SVH
`define CCP_DEFS_SVH
// Register addresses and reset values.
`define CCP_CFG_ADDR 8'hc2
`define CCP_CTL_ADDR 8'hc3
`define CCP_CFG_RST 8'h80
`define CCP_CTL_RST 8'h00
// Configuration register bit positions.
`define CCP_CFG_ENH_LV 7
`define CCP_CFG_ENH_SIG 6
`define CCP_CFG_RPTR 5
`define CCP_CFG_POL_HI 4
`define CCP_CFG_POL_LO 3
`define CCP_CFG_WAIT 2
`define CCP_CFG_QUAL 1
`define CCP_CFG_MUTE 0
// Control register bit positions.
`define CCP_CTL_RESET 7
`define CCP_CTL_RSVD 6
`define CCP_CTL_KLIST 5
`define CCP_CTL_KEY 4
`define CCP_CTL_ENC_OFF 3
`define CCP_CTL_ENC_ON 2
`define CCP_CTL_PROT_OFF 1
`define CCP_CTL_PROT_ON 0
// Start-up wait timing.
`define CCP_WAIT_MS 100
`define CCP_CLK_HZ 20000000
`define CCP_WAIT_CYCLES (`CCP_WAIT_MS * (`CCP_CLK_HZ / 1000))
`define CCP_WAIT_CNT_W 22
// Edges after reset release before the strap is sampled.
`define CCP_STRAP_LOAD 2'h2
`endif

// *** pkg/ccp_pkg.sv ***
`default_nettype none
package ccp_pkg;
   // Encryption policy encodings.
   typedef enum logic [1:0] {
      POL_AUTH = 2'b00,
      POL_REG = 2'b01,
      POL_ALWAYS = 2'b10,
      POL_FRAME = 2'b11
   } ccp_policy_t;
   // Start-up wait timer states.
   typedef enum logic {
      WT_IDLE = 1'b0,
      WT_RUN = 1'b1
   } ccp_wait_t;
   // Whole state of the control block.
   typedef struct packed {
      logic strapMeta;
      logic strapSync;
      logic [1:0] strapCnt;
      logic strapDone;
      logic enhLv;
      logic enhSig;
      logic rptr;
      ccp_policy_t policy;
      logic waitEn;
      logic qualify;
      logic muteReq;
      logic resetPulse;
      logic authEn;
      logic restartPulse;
      logic keyListOk;
      logic keyOk;
      logic encOn;
      logic frameEnc;
      logic videoEnc;
      logic videoBlue;
      logic rxIrq;
      ccp_wait_t waitState;
      logic [21:0] waitCnt;
      logic waitDone;
      logic [7:0] rdData;
      logic rdValid;
   } ccp_state_t;
endpackage : ccp_pkg
`default_nettype wire

// *** logic/ccp_content_protect_control.sv ***
// Function
// - Two-bit policy selects how encryption is decided.
// - Policy defaults per-frame with strap, else authenticated.
// - Wait bit inserts a 100 ms start-up delay.
// - Qualify clear: detect alone raises detect interrupt.
// - Qualify set: interrupt also needs receive lock.
// - Mute ignores in-band encryption status controls.
// - Reset bit resets transmitter, self-clears, resets 0x00.
// - Downstream keys bit set by host, cleared on completion.
// - Receiver key bit cleared when key-ready asserts.
// - Encrypt-off bit sends plain video, self-clears.
// - Encrypt-on: encrypted if authenticated, else blue screen.
// - Always-encrypt policy makes encrypt-on read one.
// - Protect-off bit disables authentication, self-clears.
// - Protect-on bit enables or restarts authentication.
// - Protect-on reads back current enabled status.
// - Control bit 6 is reserved, reads zero.
// - Config bit 6 selects enhanced status signalling.
`timescale 1ns/1ps
`default_nettype none
`include "ccp_defs.svh"

module ccp_content_protect_control #(
   parameter int WAIT_CYCLES = `CCP_WAIT_CYCLES
) (
   input wire logic sys_clk, // System clock, 20 MHz.
   input wire logic rst, // Synchronous reset, active high.
   input wire logic [7:0] regAddr, // Register address.
   input wire logic regWrEn, // Write strobe.
   input wire logic [7:0] regWrData, // Write data.
   input wire logic regRdEn, // Read strobe.
   output logic [7:0] regRdData, // Read data, registered.
   output logic regRdValid, // Read data valid pulse.
   input wire logic repeaterStrap, // Repeater strap pin.
   input wire logic authenticated, // Authentication engine reports success.
   input wire logic keyListDone, // Engine finished the downstream key step.
   input wire logic receiverKeyReady, // Receiver key ready status flag.
   input wire logic frameStart, // Start of a video frame.
   input wire logic frameEncryptReq, // In-band per-frame encryption request.
   input wire logic waitStart, // Engine asks for the start-up wait.
   input wire logic rxDetected, // Remote receiver detected.
   input wire logic rxLocked, // Remote receiver reports lock.
   output logic protectReset, // Transmitter reset pulse.
   output logic authEnable, // Authentication enabled level.
   output logic authRestart, // Authentication start or restart pulse.
   output logic downstreamKeysOk, // Downstream key list accepted by host.
   output logic receiverKeyOk, // Receiver key accepted by host.
   output logic encryptVideo, // Send encrypted video.
   output logic blueScreen, // Send blue screen.
   output logic avMute, // Audio and video mute active.
   output logic enhancedSignalling, // Enhanced status signalling chosen.
   output logic enhancedLinkVerify, // Enhanced link verification chosen.
   output logic repeaterMode, // Transmitter repeater mode.
   output logic waitBusy, // Start-up wait running.
   output logic waitDone, // Start-up wait finished pulse.
   output logic rxDetectIrq // Receiver detect interrupt level.
);

   // ************************************************************
   // State and decode
   // ************************************************************

   localparam logic [21:0] WAIT_LAST = 22'(WAIT_CYCLES - 1);

   ccp_pkg::ccp_state_t st_r;
   ccp_pkg::ccp_state_t st_nxt;
   logic cfgWr;
   logic ctlWr;

   // Address decode of the two registers.
   always_comb begin
      cfgWr = 1'b0;
      ctlWr = 1'b0;
      if (regWrEn && regAddr == `CCP_CFG_ADDR) begin
         cfgWr = 1'b1;
      end else if (regWrEn && regAddr == `CCP_CTL_ADDR) begin
         ctlWr = 1'b1;
      end
   end

   // ************************************************************
   // Next-state logic
   // ************************************************************

   // Computes every next value of the block state.
   always_comb begin
      st_nxt = st_r;
      st_nxt.resetPulse = 1'b0;
      st_nxt.restartPulse = 1'b0;
      st_nxt.waitDone = 1'b0;
      st_nxt.rdValid = 1'b0;
      // Strap passes two flip-flops before use.
      st_nxt.strapMeta = repeaterStrap;
      st_nxt.strapSync = st_r.strapMeta;
      if (!st_r.strapDone) begin
         if (st_r.strapCnt == `CCP_STRAP_LOAD) begin
            st_nxt.strapDone = 1'b1;
            st_nxt.policy = st_r.strapSync ? ccp_pkg::POL_FRAME : ccp_pkg::POL_AUTH;
         end else begin
            st_nxt.strapCnt = st_r.strapCnt + 2'h1;
         end
      end
      // Configuration write.
      if (cfgWr) begin
         st_nxt.enhLv = regWrData[`CCP_CFG_ENH_LV];
         st_nxt.enhSig = regWrData[`CCP_CFG_ENH_SIG];
         st_nxt.rptr = regWrData[`CCP_CFG_RPTR];
         st_nxt.policy = ccp_pkg::ccp_policy_t'(regWrData[`CCP_CFG_POL_HI:`CCP_CFG_POL_LO]);
         st_nxt.waitEn = regWrData[`CCP_CFG_WAIT];
         st_nxt.qualify = regWrData[`CCP_CFG_QUAL];
         st_nxt.muteReq = regWrData[`CCP_CFG_MUTE] & regWrData[`CCP_CFG_ENH_SIG];
      end
      if (keyListDone) begin
         st_nxt.keyListOk = 1'b0;
      end
      if (receiverKeyReady) begin
         st_nxt.keyOk = 1'b0;
      end
      // Control write; sets here win over the clears above.
      if (ctlWr) begin
         if (regWrData[`CCP_CTL_RESET]) begin
            st_nxt.resetPulse = 1'b1;
            st_nxt.authEn = 1'b0;
            st_nxt.keyListOk = 1'b0;
            st_nxt.keyOk = 1'b0;
         end else begin
            if (regWrData[`CCP_CTL_PROT_OFF]) begin
               st_nxt.authEn = 1'b0;
            end else if (regWrData[`CCP_CTL_PROT_ON]) begin
               st_nxt.authEn = 1'b1;
               st_nxt.restartPulse = 1'b1;
            end
            if (regWrData[`CCP_CTL_KLIST]) begin
               st_nxt.keyListOk = 1'b1;
            end
            if (regWrData[`CCP_CTL_KEY]) begin
               st_nxt.keyOk = 1'b1;
            end
         end
         st_nxt.encOn = regWrData[`CCP_CTL_ENC_OFF] ? 1'b0 : regWrData[`CCP_CTL_ENC_ON];
      end
      if (frameStart && !(st_r.muteReq && st_r.enhSig)) begin
         st_nxt.frameEnc = frameEncryptReq;
      end
      case (st_r.policy)
         ccp_pkg::POL_AUTH: begin
            st_nxt.videoEnc = authenticated;
            st_nxt.videoBlue = 1'b0;
         end
         ccp_pkg::POL_REG: begin
            st_nxt.videoEnc = st_r.encOn & authenticated;
            st_nxt.videoBlue = st_r.encOn & ~authenticated;
         end
         ccp_pkg::POL_ALWAYS: begin
            st_nxt.videoEnc = authenticated;
            st_nxt.videoBlue = ~authenticated;
         end
         default: begin
            st_nxt.videoEnc = st_r.frameEnc & authenticated;
            st_nxt.videoBlue = st_r.frameEnc & ~authenticated;
         end
      endcase
      st_nxt.rxIrq = rxDetected & (~st_r.qualify | rxLocked);
      case (st_r.waitState)
         ccp_pkg::WT_IDLE: begin
            if (waitStart && st_r.waitEn) begin
               st_nxt.waitState = ccp_pkg::WT_RUN;
               st_nxt.waitCnt = WAIT_LAST;
            end else if (waitStart) begin
               st_nxt.waitDone = 1'b1;
            end
         end
         default: begin
            if (st_r.waitCnt == 22'h0) begin
               st_nxt.waitState = ccp_pkg::WT_IDLE;
               st_nxt.waitDone = 1'b1;
            end else begin
               st_nxt.waitCnt = st_r.waitCnt - 22'h1;
            end
         end
      endcase
      // Register reads, unmapped addresses answer zero.
      if (regRdEn) begin
         st_nxt.rdValid = 1'b1;
         st_nxt.rdData = 8'h00;
         if (regAddr == `CCP_CFG_ADDR) begin
            st_nxt.rdData = {st_r.enhLv, st_r.enhSig, st_r.rptr, st_r.policy,
                             st_r.waitEn, st_r.qualify, st_r.muteReq};
         end else if (regAddr == `CCP_CTL_ADDR) begin
            st_nxt.rdData = {1'b0, 1'b0, st_r.keyListOk, st_r.keyOk, 1'b0,
                             st_r.encOn | (st_r.policy == ccp_pkg::POL_ALWAYS),
                             1'b0, st_r.authEn};
         end
      end
   end

   // Registers the state; reset gives every field a constant.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_r <= '0;
         st_r.enhLv <= 1'(`CCP_CFG_RST >> `CCP_CFG_ENH_LV);
         st_r.policy <= ccp_pkg::POL_AUTH;
         st_r.waitState <= ccp_pkg::WT_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************

   // Outputs come from state flip-flops; avMute and waitBusy are decoded from them.
   assign regRdData = st_r.rdData;
   assign regRdValid = st_r.rdValid;
   assign protectReset = st_r.resetPulse;
   assign authEnable = st_r.authEn;
   assign authRestart = st_r.restartPulse;
   assign downstreamKeysOk = st_r.keyListOk;
   assign receiverKeyOk = st_r.keyOk;
   assign encryptVideo = st_r.videoEnc;
   assign blueScreen = st_r.videoBlue;
   assign avMute = st_r.muteReq & st_r.enhSig;
   assign enhancedSignalling = st_r.enhSig;
   assign enhancedLinkVerify = st_r.enhLv;
   assign repeaterMode = st_r.rptr;
   assign waitBusy = (st_r.waitState == ccp_pkg::WT_RUN);
   assign waitDone = st_r.waitDone;
   assign rxDetectIrq = st_r.rxIrq;

   // ************************************************************
   // Assertions
   // ************************************************************

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_strap_default: assert property ($rose(st_r.strapDone) && !$past(cfgWr) |->
      st_r.policy == ($past(st_r.strapSync) ? ccp_pkg::POL_FRAME : ccp_pkg::POL_AUTH))
      else $error("Policy default does not follow strap.");
   a_policy_auth: assert property (st_r.policy == ccp_pkg::POL_AUTH |=>
      encryptVideo == $past(authenticated) && !blueScreen)
      else $error("Authenticated policy output wrong.");
   a_policy_always: assert property (st_r.policy == ccp_pkg::POL_ALWAYS |=>
      encryptVideo == $past(authenticated) && blueScreen == !$past(authenticated))
      else $error("Always policy output wrong.");
   a_wait_skip: assert property (waitStart && !st_r.waitEn && !waitBusy |=>
      waitDone && !waitBusy) else $error("Disabled wait did not finish at once.");
   a_wait_holds: assert property (waitStart && st_r.waitEn && !waitBusy |=>
      (waitBusy && !waitDone) [*8]) else $error("Enabled wait ended too early.");
   a_rxdet_plain: assert property (rxDetected && !st_r.qualify |=> rxDetectIrq)
      else $error("Detect interrupt missing.");
   a_rxdet_locked: assert property (st_r.qualify && !rxLocked |=> !rxDetectIrq)
      else $error("Detect interrupt raised without lock.");
   a_mute_freeze: assert property (avMute && frameStart |=> $stable(st_r.frameEnc))
      else $error("In-band status taken during mute.");
   a_frame_take: assert property (frameStart && !avMute |=>
      st_r.frameEnc == $past(frameEncryptReq)) else $error("In-band request not taken.");
   a_mute_refused: assert property (cfgWr && !regWrData[`CCP_CFG_ENH_SIG] |=> !avMute)
      else $error("Mute kept without enhanced signalling.");
   a_reset_pulse: assert property (ctlWr && regWrData[`CCP_CTL_RESET] |=>
      protectReset && !authEnable ##1 !protectReset)
      else $error("Reset bit did not pulse once.");
   a_list_clear: assert property (keyListDone && !(ctlWr && regWrData[`CCP_CTL_KLIST])
      |=> !downstreamKeysOk) else $error("Downstream key bit not cleared.");
   a_key_clear: assert property (receiverKeyReady && !(ctlWr && regWrData[`CCP_CTL_KEY])
      |=> !receiverKeyOk) else $error("Receiver key bit not cleared.");
   a_encrypt_off: assert property (ctlWr && regWrData[`CCP_CTL_ENC_OFF] |=> !st_r.encOn)
      else $error("Encrypt-off did not clear encrypt-on.");
   a_blue_screen: assert property (st_r.policy == ccp_pkg::POL_REG && st_r.encOn &&
      !authenticated |=> blueScreen && !encryptVideo) else $error("Blue screen missing.");
   a_plain_video: assert property (st_r.policy == ccp_pkg::POL_REG && !st_r.encOn |=>
      !blueScreen && !encryptVideo) else $error("Video not sent plain.");
   a_always_read: assert property (regRdEn && regAddr == `CCP_CTL_ADDR &&
      st_r.policy == ccp_pkg::POL_ALWAYS |=> regRdData[`CCP_CTL_ENC_ON])
      else $error("Encrypt-on not read as one.");
   a_live_status: assert property (regRdEn && regAddr == `CCP_CTL_ADDR |=>
      regRdData[`CCP_CTL_PROT_ON] == $past(authEnable)) else $error("Enable status misread.");
   a_reserved_zero: assert property (regRdEn && regAddr == `CCP_CTL_ADDR |=>
      !regRdData[`CCP_CTL_RSVD]) else $error("Reserved bit not zero.");
   a_signal_select: assert property (cfgWr |=>
      enhancedSignalling == $past(regWrData[`CCP_CFG_ENH_SIG]))
      else $error("Signalling bit not stored.");
   a_disable_wins: assert property (ctlWr && regWrData[`CCP_CTL_PROT_OFF] |=>
      !authEnable && !authRestart) else $error("Disable did not win.");
   a_enable_restart: assert property (ctlWr && regWrData[`CCP_CTL_PROT_ON] &&
      !regWrData[`CCP_CTL_PROT_OFF] && !regWrData[`CCP_CTL_RESET] |=>
      authEnable && authRestart) else $error("Enable did not restart.");

   // Main scenarios.
   c_auth_restart: cover property (authEnable && ctlWr && regWrData[`CCP_CTL_PROT_ON]);
   c_wait_done: cover property (waitBusy ##1 waitDone);
   c_frame_encrypt: cover property (st_r.policy == ccp_pkg::POL_FRAME && encryptVideo);
   c_blue_screen: cover property (blueScreen && st_r.policy == ccp_pkg::POL_REG);
   c_mute_frame: cover property (avMute && frameStart);

endmodule : ccp_content_protect_control
`default_nettype wire

// *** verification/ccp_rx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Remote receiver model seen across the serial link.
// ************************************************************
module ccp_rx_model #(
   parameter int LOCK_DLY = 3
) (
   input wire logic sys_clk, // System clock.
   input wire logic rst, // Synchronous reset.
   input wire logic plugIn, // Receiver attached to the link.
   input wire logic lockOk, // Receiver is able to lock.
   output logic rxDetected, // Receiver detect level.
   output logic rxLocked // Receive lock level.
);
   logic [3:0] lockCnt_r;
   // Counts edges since attach so that lock trails detection.
   always_ff @(posedge sys_clk) begin
      if (rst || !plugIn) begin
         lockCnt_r <= 4'h0;
      end else if (lockCnt_r != 4'(LOCK_DLY)) begin
         lockCnt_r <= lockCnt_r + 4'h1;
      end
   end
   // Detect follows attach; lock only when allowed and settled.
   assign rxDetected = (lockCnt_r != 4'h0);
   assign rxLocked = lockOk && (lockCnt_r == 4'(LOCK_DLY));
endmodule : ccp_rx_model
`default_nettype wire

// *** verification/ccp_content_protect_control_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Self-checking bench for the protection control registers.
// ************************************************************
module ccp_content_protect_control_tb_top;
   localparam int WT = 20;
   logic sys_clk, rst, regWrEn, regRdEn, repeaterStrap, authenticated, keyListDone;
   logic receiverKeyReady, frameStart, frameEncryptReq, waitStart, plugIn, lockOk;
   logic [7:0] regAddr, regWrData, regRdData;
   logic regRdValid, protectReset, authEnable, authRestart, downstreamKeysOk;
   logic receiverKeyOk, encryptVideo, blueScreen, avMute, enhancedSignalling;
   logic enhancedLinkVerify, repeaterMode, waitBusy, waitDone, rxDetectIrq;
   logic rxDetected, rxLocked, e, f;
   logic [1:0] pol;
   logic [31:0] lfsr;
   int error_cnt, comparisons, n;

   ccp_content_protect_control #(.WAIT_CYCLES(WT)) u_ccp_content_protect_control (
      .sys_clk, .rst, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData,
      .regRdValid, .repeaterStrap, .authenticated, .keyListDone, .receiverKeyReady,
      .frameStart, .frameEncryptReq, .waitStart, .rxDetected, .rxLocked,
      .protectReset, .authEnable, .authRestart, .downstreamKeysOk, .receiverKeyOk,
      .encryptVideo, .blueScreen, .avMute, .enhancedSignalling, .enhancedLinkVerify,
      .repeaterMode, .waitBusy, .waitDone, .rxDetectIrq);

   ccp_rx_model u_ccp_rx_model (.sys_clk, .rst, .plugIn, .lockOk, .rxDetected,
      .rxLocked);

   // Free-running 20 MHz clock.
   initial begin
      sys_clk = 1'h0;
      forever #25 sys_clk = ~sys_clk;
   end

   // Compares one value and counts the outcome.
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict

   // Next value of the stimulus shift register.
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next

   // Expected encrypt and blue-screen levels for a policy.
   function automatic logic [1:0] vid_exp(input logic [1:0] p, input logic en,
      input logic a, input logic fr);
      case (p)
         2'h0: vid_exp = {a, 1'h0};
         2'h1: vid_exp = {en & a, en & !a};
         2'h2: vid_exp = {a, !a};
         default: vid_exp = {fr & a, fr & !a};
      endcase
   endfunction : vid_exp

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      regWrEn = 1'h1;
      regAddr = a;
      regWrData = d;
      @(negedge sys_clk);
      regWrEn = 1'h0;
   endtask : wr

   task automatic rdreg(input logic [7:0] a, input logic [7:0] exp);
      @(negedge sys_clk);
      regRdEn = 1'h1;
      regAddr = a;
      @(negedge sys_clk);
      regRdEn = 1'h0;
      chk({regRdValid, 7'h0}, 8'h80);
      chk(regRdData, exp);
   endtask : rdreg

   task automatic do_reset(input logic s);
      repeaterStrap = s;
      rst = 1'h1;
      repeat (8) @(negedge sys_clk);
      rst = 1'h0;
      repeat (4) @(negedge sys_clk);
   endtask : do_reset

   task automatic frm(input logic fr);
      frameEncryptReq = fr;
      frameStart = 1'h1;
      @(negedge sys_clk);
      frameStart = 1'h0;
      repeat (2) @(negedge sys_clk);
   endtask : frm

   // Main sequence of scenarios.
   initial begin
      {error_cnt, comparisons} = '0;
      {rst, regWrEn, regRdEn, repeaterStrap, authenticated, keyListDone} = 6'h20;
      {receiverKeyReady, frameStart, frameEncryptReq, waitStart, plugIn, lockOk} = 6'h00;
      {regAddr, regWrData} = 16'h0000;
      lfsr = 32'h0001_5f00;
      for (int s = 0; s < 2; s++) begin
         do_reset(s[0]);
         rdreg(8'hc2, s[0] ? 8'h98 : 8'h80);
         rdreg(8'hc3, 8'h00);
         chk({enhancedLinkVerify, enhancedSignalling, avMute, 5'h0}, 8'h80);
      end
      wr(8'h10, 8'hff);
      rdreg(8'hc2, 8'h98);
      rdreg(8'hc4, 8'h00);
      wr(8'hc3, 8'h01);
      chk({6'h0, authEnable, authRestart}, 8'h03);
      @(negedge sys_clk);
      chk({6'h0, authEnable, authRestart}, 8'h02);
      wr(8'hc3, 8'h00);
      rdreg(8'hc3, 8'h01);
      wr(8'hc3, 8'h01);
      chk({6'h0, authEnable, authRestart}, 8'h03);
      wr(8'hc3, 8'h02);
      rdreg(8'hc3, 8'h00);
      wr(8'hc3, 8'h01);
      wr(8'hc3, 8'h03);
      chk({6'h0, authEnable, authRestart}, 8'h00);
      wr(8'hc3, 8'h31);
      rdreg(8'hc3, 8'h31);
      wr(8'hc3, 8'h80);
      chk({4'h0, protectReset, authEnable, downstreamKeysOk, receiverKeyOk}, 8'h08);
      @(negedge sys_clk);
      chk({7'h0, protectReset}, 8'h00);
      rdreg(8'hc3, 8'h00);
      // key confirmations clear on engine flags.
      wr(8'hc3, 8'h70);
      rdreg(8'hc3, 8'h30);
      wr(8'hc3, 8'h00);
      chk({6'h0, downstreamKeysOk, receiverKeyOk}, 8'h03);
      keyListDone = 1'h1;
      @(negedge sys_clk);
      keyListDone = 1'h0;
      chk({6'h0, downstreamKeysOk, receiverKeyOk}, 8'h01);
      receiverKeyReady = 1'h1;
      @(negedge sys_clk);
      receiverKeyReady = 1'h0;
      chk({6'h0, downstreamKeysOk, receiverKeyOk}, 8'h00);
      wr(8'hc3, 8'h01);
      for (int i = 0; i < 24; i++) begin
         lfsr = lfsr_next(lfsr);
         {f, authenticated, e, pol} = lfsr[4:0];
         wr(8'hc2, {3'h6, pol, 3'h0});
         wr(8'hc3, {5'h0, e, 2'h0});
         if (lfsr[5]) begin
            wr(8'hc3, 8'h08);
            e = 1'h0;
         end
         frm(f);
         chk({6'h0, encryptVideo, blueScreen}, {6'h0, vid_exp(pol, e, lfsr[3], f)});
         rdreg(8'hc3, {5'h0, e | (pol == 2'h2), 2'h1});
      end
      authenticated = 1'h1;
      wr(8'hc3, 8'h04);
      wr(8'hc2, 8'hd8);
      frm(1'h1);
      wr(8'hc2, 8'hd9);
      frm(1'h0);
      chk({6'h0, avMute, encryptVideo}, 8'h03);
      wr(8'hc2, 8'h99);
      rdreg(8'hc2, 8'h98);
      frm(1'h0);
      chk({6'h0, avMute, encryptVideo}, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(8'hc2, {6'h20, i[0], 1'h0});
         plugIn = i[1];
         lockOk = i[2];
         repeat (6) @(negedge sys_clk);
         chk({7'h0, rxDetectIrq}, {7'h0, i[1] & (!i[0] | i[2])});
      end
      wr(8'hc2, 8'h60);
      chk({5'h0, repeaterMode, enhancedLinkVerify, enhancedSignalling}, 8'h05);
      // start-up wait, with a refused restart while busy.
      for (int w = 0; w < 2; w++) begin
         wr(8'hc2, {5'h10, w[0], 2'h0});
         waitStart = 1'h1;
         n = 0;
         while (n < 100 && waitDone !== 1'h1) begin
            @(negedge sys_clk);
            n++;
            waitStart = (n == 5);
            if (n == 1) begin
               chk({7'h0, waitBusy}, {7'h0, w[0]});
            end
         end
         waitStart = 1'h0;
         if (n == 100) begin
            error_cnt++;
            break;
         end
         chk(n[7:0], w[0] ? 8'(WT + 1) : 8'h01);
         @(negedge sys_clk);
         chk({waitBusy, waitDone, 6'h0}, 8'h00);
      end
      print_verdict();
   end
endmodule : ccp_content_protect_control_tb_top
`default_nettype wire
